// file: include/sac_pkg.sv
// Package for the sampled address capture block.
// Assumes one processor clock domain and 64-bit effective addresses.
package sac_pkg;
  // ----------------------------------------
  // Widths and bit positions
  // ----------------------------------------
  localparam int unsigned SAC_ADDR_W       = 64;
  localparam int unsigned SAC_SAMPLE_BIT   = 63;
  localparam int unsigned SAC_SAME_BIT     = 33;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [SAC_ADDR_W-1:0] SAC_ADDR_RST = 64'h0;
  localparam logic                  SAC_BIT_RST  = 1'b0;
  // ----------------------------------------
  // Marking cycle states
  // ----------------------------------------
  typedef enum logic [3:0] {
    SAC_IDLE     = 4'b0001,
    SAC_INFLIGHT = 4'b0010,
    SAC_TRAPWAIT = 4'b0100,
    SAC_POSTTRAP = 4'b1000
  } sac_state_type;
endpackage

// file: include/sac_cap_if.sv
// Carrier between the top and its capture register module.
// Assumes both ends share the processor clock.
`timescale 1ns/10ps
`default_nettype none
interface sac_cap_if;
  import sac_pkg::*;
  logic                  load_instr;
  logic [SAC_ADDR_W-1:0] instr_addr;
  logic                  load_data;
  logic [SAC_ADDR_W-1:0] data_addr;
  logic                  clear_same;
  logic                  set_same;
  logic [SAC_ADDR_W-1:0] instr_q;
  logic [SAC_ADDR_W-1:0] data_q;
  logic                  same_q;
  modport ctrl (output load_instr, instr_addr, load_data, data_addr, clear_same, set_same,
                input instr_q, data_q, same_q);
  modport regs (input load_instr, instr_addr, load_data, data_addr, clear_same, set_same,
                output instr_q, data_q, same_q);
endinterface
`default_nettype wire

// file: src/sac_regs.sv
// Sampled address registers and the same-instruction bit.
// Assumes the controller gates all loads; reset already synchronised.
`timescale 1ns/10ps
`default_nettype none
module sac_regs (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  input  wire logic clk_en_i,
  // Controller side
  sac_cap_if.regs   cap
);
  import sac_pkg::*;
  typedef struct packed {
    logic [SAC_ADDR_W-1:0] instr;
    logic [SAC_ADDR_W-1:0] data;
    logic                  same;
  } sac_regs_type;
  sac_regs_type st_reg;
  sac_regs_type st_next;
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (cap.load_instr) begin
      st_next.instr = cap.instr_addr;
    end
    if (cap.load_data) begin
      st_next.data = cap.data_addr;
    end
    // Set beats clear when both land together
    if (cap.clear_same) begin
      st_next.same = 1'b0;
    end
    if (cap.set_same) begin
      st_next.same = 1'b1;
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '{SAC_ADDR_RST, SAC_ADDR_RST, SAC_BIT_RST};
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end
  assign cap.instr_q = st_reg.instr;
  assign cap.data_q  = st_reg.data;
  assign cap.same_q  = st_reg.same;
endmodule
`default_nettype wire

// file: src/sac_top.sv
// Sampled address capture: mode select, marking cycle, freeze and exception raise.
// Assumes pipeline strobes are single-cycle pulses on the processor clock.
//
// Summary of operation
// R1 - Sampling mode when sample bit set and both trace enables clear.
// R2 - Software clears sample bit before enabling tracing; mixed setting undefined.
// R3 - Sampling cycles run even with no counter enabled.
// R4 - Sampling cycle starts at decode mark, ends at completion or flush.
// R5 - Exception condition: negative counter or time-base event, each when enabled.
// R6 - At exception, instruction register holds last sampled instruction address.
// R7 - Data register holds operand address of last sampled load/store.
// R8 - Without tracing, exception freezes registers and clears exception enable.
// R9 - Without tracing, registers update only while exception enable set.
// R10 - Enabled exception with interrupts on is taken, reporting same-instruction bit.
// R11 - Same bit one means both registers describe one instruction.
// R12 - Under tracing registers and same bit may change regardless of enable.
// R13 - Trace modes disable sampling; marked events follow trace marks.
// R14 - Single-step marks every instruction and forces single dispatch.
// R15 - Single-step marks at decode-to-issue transfer and clears same bit.
// R16 - Single-step loads instruction address at dispatch, operand via load/store.
// R17 - Trace-marked completion raises trace exception; flush after handler return.
// R18 - Between handler return and next dispatch registers keep last instruction.
// R19 - Branch trace marks each branch, loads instruction address at dispatch.
// R20 - After post-trap flush, next decoded branch is marked again.
// R21 - Reset clears sample bit and marking fields; marking starts disabled.
// R22 - While sampling and enabled, each new sampled instruction overwrites registers.
`timescale 1ns/10ps
`default_nettype none
module sac_top
  import sac_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           clk_en_i,
  // Monitor control and machine state
  input  wire logic                           sample_bit_wr_i,
  input  wire logic                           sample_bit_val_i,
  input  wire logic                           pm_exception_enable_set_i,
  input  wire logic                           neg_exc_enable_i,
  input  wire logic                           tb_exc_enable_i,
  input  wire logic                           single_step_enable_i,
  input  wire logic                           branch_trace_enable_i,
  input  wire logic                           external_irq_enable_i,
  // Performance counter events
  input  wire logic                           counter_negative_i,
  input  wire logic                           time_base_event_i,
  // Decode unit
  input  wire logic                           decode_candidate_i,
  input  wire logic                           decode_is_branch_i,
  input  wire logic                           decode_xfer_i,
  input  wire logic [sac_pkg::SAC_ADDR_W-1:0] decode_addr_i,
  // Issue and completion
  input  wire logic                           dispatch_i,
  input  wire logic                           complete_i,
  input  wire logic                           flush_i,
  input  wire logic                           handler_return_i,
  // Load/store unit
  input  wire logic                           lsu_marked_op_i,
  input  wire logic [sac_pkg::SAC_ADDR_W-1:0] lsu_ea_i,
  // Marking and exception outputs
  output logic                                mark_o,
  output logic                                single_dispatch_o,
  output logic                                sampling_mode_o,
  output logic                                trace_mode_o,
  output logic                                pm_exception_enable_o,
  output logic                                sample_enable_o,
  output logic                                pm_exc_take_o,
  output logic                                trace_exc_o,
  output logic                                global_flush_o,
  output logic                                marked_event_o,
  // Sampled values
  output logic [sac_pkg::SAC_ADDR_W-1:0]      sampled_instr_addr_o,
  output logic [sac_pkg::SAC_ADDR_W-1:0]      sampled_data_addr_o,
  output logic                                save_restore_1_same_o
);
  import sac_pkg::*;
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_b;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_reg[1];
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    sac_state_type state;
    logic          sample_en;
    logic          pm_exception_enable;
    logic          in_trace;
    logic          pend_addr_ld;
    logic          trap;
    logic          take;
    logic          flush;
    logic          mark;
    logic [SAC_ADDR_W-1:0] mark_addr;
  } sac_top_type;
  sac_top_type st_reg;
  sac_top_type st_next;
  sac_cap_if cap ();
  logic sampling;
  logic tracing;
  logic pm_cond;
  logic can_update;
  logic mark_now;
  assign tracing  = single_step_enable_i | branch_trace_enable_i; // R2
  assign sampling = st_reg.sample_en & ~tracing; // R1 R13
  assign pm_cond  = (counter_negative_i & neg_exc_enable_i) | (time_base_event_i & tb_exc_enable_i); // R5
  // Frozen outside tracing unless enable is set; tracing ignores it
  assign can_update = tracing | st_reg.pm_exception_enable; // R9 R12
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next      = st_reg;
    st_next.trap = 1'b0;
    st_next.take = 1'b0;
    st_next.flush = 1'b0;
    st_next.mark = 1'b0;
    mark_now     = 1'b0;
    if (sample_bit_wr_i) begin
      st_next.sample_en = sample_bit_val_i;
    end
    case (st_reg.state)
      SAC_IDLE: begin
        if (decode_xfer_i) begin
          if (single_step_enable_i) begin
            mark_now = 1'b1; // R14 R15
          end else if (branch_trace_enable_i) begin
            mark_now = decode_is_branch_i; // R19 R20
          end else if (sampling) begin
            mark_now = decode_candidate_i; // R3 R4
          end
        end
        if (mark_now) begin
          st_next.state     = SAC_INFLIGHT;
          st_next.mark      = 1'b1;
          st_next.in_trace  = tracing;
          st_next.mark_addr = decode_addr_i;
          st_next.pend_addr_ld = 1'b1;
        end
      end
      SAC_INFLIGHT: begin
        if (flush_i) begin
          st_next.state = SAC_IDLE; // R4
        end else if (complete_i) begin
          if (st_reg.in_trace) begin
            st_next.trap  = 1'b1; // R17
            st_next.state = SAC_TRAPWAIT;
          end else begin
            st_next.state = SAC_IDLE; // R4
          end
        end
        if (dispatch_i) begin
          st_next.pend_addr_ld = 1'b0;
        end
      end
      SAC_TRAPWAIT: begin
        // Registers hold the completed instruction until next dispatch
        if (handler_return_i) begin
          st_next.flush = 1'b1; // R17 R18
          st_next.state = SAC_POSTTRAP;
        end
      end
      SAC_POSTTRAP: begin
        st_next.state = SAC_IDLE; // R20
      end
      default: begin
        st_next.state = SAC_IDLE;
      end
    endcase
    // Outside tracing, freeze and clear enable on exception; software set wins after
    if (pm_cond & st_reg.pm_exception_enable & ~tracing) begin
      st_next.pm_exception_enable = 1'b0; // R8
      st_next.take = external_irq_enable_i; // R10
    end else if (pm_cond & st_reg.pm_exception_enable) begin
      st_next.take = external_irq_enable_i; // R10
    end
    if (pm_exception_enable_set_i) begin
      st_next.pm_exception_enable = 1'b1; // R9
    end
  end
  // Loads into capture registers
  assign cap.load_instr = dispatch_i & st_reg.pend_addr_ld & (st_reg.state == SAC_INFLIGHT)
                          & can_update & ~(pm_cond & ~tracing); // R6 R16 R19 R22
  assign cap.instr_addr = st_reg.mark_addr;
  assign cap.load_data  = lsu_marked_op_i & (st_reg.state == SAC_INFLIGHT)
                          & can_update & ~(pm_cond & ~tracing)
                          & ~(branch_trace_enable_i & ~single_step_enable_i); // R7 R16
  assign cap.data_addr  = lsu_ea_i;
  assign cap.clear_same = st_next.mark & can_update; // R15
  assign cap.set_same   = cap.load_data; // R11 R16
  sac_regs u_regs (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b),
    .clk_en_i  (clk_en_i),
    .cap       (cap)
  );
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      st_reg.state        <= SAC_IDLE; // R21
      st_reg.sample_en    <= SAC_BIT_RST; // R21
      st_reg.pm_exception_enable         <= SAC_BIT_RST;
      st_reg.in_trace     <= 1'b0;
      st_reg.pend_addr_ld <= 1'b0;
      st_reg.trap         <= 1'b0;
      st_reg.take         <= 1'b0;
      st_reg.flush        <= 1'b0;
      st_reg.mark         <= 1'b0;
      st_reg.mark_addr    <= SAC_ADDR_RST;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign mark_o                = st_reg.mark;
  assign marked_event_o        = st_reg.mark; // R13
  assign single_dispatch_o     = single_step_enable_i; // R14
  assign sampling_mode_o       = sampling;
  assign trace_mode_o          = tracing;
  assign pm_exception_enable_o = st_reg.pm_exception_enable;
  assign sample_enable_o       = st_reg.sample_en;
  assign pm_exc_take_o         = st_reg.take;
  assign trace_exc_o           = st_reg.trap;
  assign global_flush_o        = st_reg.flush;
  assign sampled_instr_addr_o  = cap.instr_q;
  assign sampled_data_addr_o   = cap.data_q;
  assign save_restore_1_same_o = cap.same_q;
endmodule
`default_nettype wire

// file: verif/sac_monitor.sv
// Port checker for the sampled address capture block.
// Assumes clk_en_i drops only while the pipeline is quiet.
`timescale 1ns/10ps
`default_nettype none
module sac_monitor
  import sac_pkg::*;
(
  // Watched ports
  input wire logic sys_clk_i, rst_b_i, single_step_enable_i, branch_trace_enable_i,
  input wire logic external_irq_enable_i, neg_exc_enable_i, tb_exc_enable_i, pm_exception_enable_set_i,
  input wire logic counter_negative_i, time_base_event_i, dispatch_i, lsu_marked_op_i,
  input wire logic sample_enable_o, mark_o, single_dispatch_o, sampling_mode_o,
  input wire logic pm_exception_enable_o, pm_exc_take_o, trace_exc_o, save_restore_1_same_o,
  input wire logic [SAC_ADDR_W-1:0] decode_addr_i, lsu_ea_i, sampled_instr_addr_o, sampled_data_addr_o
);
  logic trc;
  logic pmc;
  assign trc = single_step_enable_i | branch_trace_enable_i;
  assign pmc = (counter_negative_i & neg_exc_enable_i) | (time_base_event_i & tb_exc_enable_i);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_mode; sampling_mode_o == (sample_enable_o && !trc); endproperty
  a_mode: assert property (p_mode) else $error("sampling mode wrong");
  property p_sdisp; single_dispatch_o == single_step_enable_i; endproperty
  a_sdisp: assert property (p_sdisp) else $error("single dispatch wrong");
  property p_freeze; pmc && pm_exception_enable_o && !trc && !pm_exception_enable_set_i |=> !pm_exception_enable_o; endproperty
  a_freeze: assert property (p_freeze) else $error("enable not cleared");
  property p_take; pmc && pm_exception_enable_o |=> pm_exc_take_o == $past(external_irq_enable_i); endproperty
  a_take: assert property (p_take) else $error("exception not taken");
  property p_quiet; !pm_exception_enable_o |=> !pm_exc_take_o; endproperty
  a_quiet: assert property (p_quiet) else $error("exception while disabled");
  property p_hold;
    !pm_exception_enable_o && !trc |=> $stable(sampled_instr_addr_o) && $stable(sampled_data_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("frozen address moved");
  property p_disp;
    mark_o && dispatch_i && (trc || pm_exception_enable_o) && !pmc
      |=> sampled_instr_addr_o == $past(decode_addr_i, 2);
  endproperty
  a_disp: assert property (p_disp) else $error("instr address not loaded");
  property p_lsu;
    lsu_marked_op_i && (single_step_enable_i || pm_exception_enable_o && !trc && !pmc)
      |=> sampled_data_addr_o == $past(lsu_ea_i) && save_restore_1_same_o;
  endproperty
  a_lsu: assert property (p_lsu) else $error("data address not loaded");
  property p_mclr; mark_o && single_step_enable_i |-> !save_restore_1_same_o; endproperty
  a_mclr: assert property (p_mclr) else $error("same bit not cleared");
  property p_keep; trc && !dispatch_i |=> $stable(sampled_instr_addr_o); endproperty
  a_keep: assert property (p_keep) else $error("instr address moved");
  cover property (pm_exc_take_o);
  cover property (trace_exc_o);
  cover property (mark_o && sampling_mode_o);
endmodule
bind sac_top sac_monitor u_mon (.*);
`default_nettype wire

// file: verif/sac_pipe_model.sv
// Pipeline stand-in: decode, issue, load/store, completion and handler return.
// Assumes one marked instruction at a time; go ignored while busy.
`timescale 1ns/10ps
`default_nettype none
module sac_pipe_model (
  // Command
  input  wire logic        sys_clk_i, go_i, ls_i, fl_i, trace_exc_i,
  input  wire logic [1:0]  dly_i,
  input  wire logic [63:0] addr_i, ea_i,
  // Pipeline strobes
  output logic             xfer_o, disp_o, lsu_o, done_o, flush_o, hret_o, busy_o,
  output logic [63:0]      addr_o, ea_o
);
  initial begin
    {xfer_o, disp_o, lsu_o, done_o, flush_o, hret_o, busy_o} = '0;
    {addr_o, ea_o} = '0;
  end
  // Released buses show the inverse so stale values never pass
  task automatic run();
    busy_o <= 1'b1;
    xfer_o <= 1'b1;
    addr_o <= addr_i;
    @(posedge sys_clk_i);
    {xfer_o, disp_o, addr_o} <= {2'b01, ~addr_i};
    @(posedge sys_clk_i);
    {disp_o, lsu_o, ea_o} <= {1'b0, ls_i, ea_i};
    @(posedge sys_clk_i);
    {lsu_o, ea_o} <= {1'b0, ~ea_i};
    repeat (dly_i) @(posedge sys_clk_i);
    {flush_o, done_o} <= {fl_i, !fl_i};
    @(posedge sys_clk_i);
    {flush_o, done_o} <= 2'b00;
    @(posedge sys_clk_i);
    if (trace_exc_i) begin
      repeat (3) @(posedge sys_clk_i);
      hret_o <= 1'b1;
      @(posedge sys_clk_i);
      hret_o <= 1'b0;
    end
    repeat (2) @(posedge sys_clk_i);
    busy_o <= 1'b0;
  endtask
  always @(posedge sys_clk_i) if (go_i && !busy_o) run();
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the sampled address capture block.
// Assumes the pipeline model stands for the surrounding units.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sac_pkg::*;
  typedef struct {logic sb, se, be, br, ls, fl, x, p, m; logic [63:0] a, e, xi, xd; logic xs;} sac_row_type;
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0, clk_en_i = 1'b1;
  logic sample_bit_wr_i = 1'b0, sample_bit_val_i = 1'b0, pm_exception_enable_set_i = 1'b0;
  logic neg_exc_enable_i = 1'b1, tb_exc_enable_i = 1'b1, external_irq_enable_i = 1'b1;
  logic single_step_enable_i = 1'b0, branch_trace_enable_i = 1'b0;
  logic counter_negative_i = 1'b0, time_base_event_i = 1'b0;
  logic decode_candidate_i = 1'b0, decode_is_branch_i = 1'b0;
  logic go = 1'b0, ls = 1'b0, fl = 1'b0;
  logic [63:0] ad = '0, ea = '0;
  logic decode_xfer_i, dispatch_i, complete_i, flush_i, handler_return_i, lsu_marked_op_i, busy;
  logic [SAC_ADDR_W-1:0] decode_addr_i, lsu_ea_i, sampled_instr_addr_o, sampled_data_addr_o;
  logic mark_o, single_dispatch_o, sampling_mode_o, trace_mode_o, pm_exception_enable_o;
  logic sample_enable_o, pm_exc_take_o, trace_exc_o, global_flush_o, marked_event_o, save_restore_1_same_o;
  int err_total = 0, compares = 0, n_trc = 0, n_fl = 0, n_mev = 0;
  sac_row_type rows[11] = '{
    '{1,0,0,1,1,0,0,1,1,64'h1000,64'h8000,64'h1000,64'h8000,1}, '{1,0,0,1,0,0,0,0,1,64'h1004,64'h8004,64'h1004,64'h8000,0},
    '{1,0,0,1,1,1,0,0,1,64'h1008,64'h8010,64'h1008,64'h8010,1}, '{0,1,0,0,1,0,0,0,1,64'h2000,64'h9000,64'h2000,64'h9000,1},
    '{0,1,0,0,0,0,0,0,1,64'h2004,64'h9004,64'h2004,64'h9000,0}, '{0,0,1,1,0,0,0,0,0,64'h3000,64'h0,64'h3000,64'h0,0},
    '{0,0,1,1,0,0,0,0,0,64'h3004,64'h0,64'h3004,64'h0,0}, '{0,0,1,0,0,0,0,0,0,64'h3008,64'h0,64'h3004,64'h0,0},
    '{1,0,0,0,0,0,0,0,0,64'h4000,64'h0,64'h3004,64'h0,0}, '{1,0,0,1,1,0,1,0,0,64'h5000,64'hB000,64'h3004,64'h0,0},
    '{1,0,0,1,1,0,0,1,1,64'h5004,64'hB004,64'h5004,64'hB004,1}};
  sac_pipe_model u_pipe (.sys_clk_i(sys_clk_i), .go_i(go), .ls_i(ls), .fl_i(fl), .trace_exc_i(trace_exc_o),
    .dly_i(ad[3:2]), .addr_i(ad), .ea_i(ea), .xfer_o(decode_xfer_i), .disp_o(dispatch_i),
    .lsu_o(lsu_marked_op_i), .done_o(complete_i), .flush_o(flush_i), .hret_o(handler_return_i),
    .busy_o(busy), .addr_o(decode_addr_i), .ea_o(lsu_ea_i));
  sac_top u_dut (.*);
  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (trace_exc_o === 1'b1) n_trc++;
  always @(posedge sys_clk_i) if (global_flush_o === 1'b1) n_fl++;
  always @(posedge sys_clk_i) if (marked_event_o === 1'b1) n_mev++;
  task automatic ck(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic results();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Sampling bit cleared a cycle before tracing turns on
  task automatic op(input sac_row_type r);
    @(posedge sys_clk_i);
    {sample_bit_wr_i, sample_bit_val_i, counter_negative_i, pm_exception_enable_set_i} <= {1'b1, r.sb, r.x, r.p};
    {single_step_enable_i, branch_trace_enable_i} <= 2'h0;
    @(posedge sys_clk_i);
    {sample_bit_wr_i, counter_negative_i, pm_exception_enable_set_i} <= 3'h0;
    {single_step_enable_i, branch_trace_enable_i, decode_candidate_i, decode_is_branch_i} <= {r.se, r.be, r.br, r.br};
    {go, ls, fl, ad, ea} <= {1'b1, r.ls, r.fl, r.a, r.e};
    @(posedge sys_clk_i);
    go <= 1'b0;
    repeat (40) begin
      @(posedge sys_clk_i);
      if (!busy) break;
    end
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    #1 ck(sample_enable_o === 1'b0 && pm_exception_enable_o === 1'b0 && mark_o === 1'b0, "reset");
    // Internal reset lifts two edges after the pin; earlier writes are lost
    repeat (2) @(posedge sys_clk_i);
    foreach (rows[i]) begin
      op(rows[i]);
      #1 ck(sampled_instr_addr_o === rows[i].xi, "instr addr");
      if (rows[i].m) ck(sampled_data_addr_o === rows[i].xd && save_restore_1_same_o === rows[i].xs, "data");
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk_i);
      {pm_exception_enable_set_i, external_irq_enable_i, neg_exc_enable_i} <= {1'b1, k[0], k != 2};
      @(posedge sys_clk_i);
      {pm_exception_enable_set_i, counter_negative_i, time_base_event_i} <= {1'b0, ~k[0], k[0]};
      @(posedge sys_clk_i);
      {counter_negative_i, time_base_event_i} <= 2'h0;
      #1 ck(pm_exc_take_o === k[0] && pm_exception_enable_o === (k == 2), "exception");
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      {branch_trace_enable_i, single_step_enable_i} <= i[1:0];
      #1 ck(sampling_mode_o === (i == 0) && single_dispatch_o === i[0], "mode");
      ck(trace_mode_o === (i != 0), "trace mode");
    end
    // Clock enable low must swallow a sample bit write
    @(posedge sys_clk_i);
    {clk_en_i, sample_bit_wr_i, sample_bit_val_i} <= 3'b010;
    @(posedge sys_clk_i);
    {clk_en_i, sample_bit_wr_i} <= 2'b10;
    #1 ck(sample_enable_o === 1'b1, "clock enable");
    ck(n_trc == 4 && n_fl == 4, "trace exceptions");
    ck(n_mev == 9, "marked events");
    results();
  end
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    err_total++;
    results();
  end
endmodule
`default_nettype wire
